// *** hdl/parallel_programmer_input_port.sv ***
/*
  Parallel input port of a two-channel digital programmer with an APB register slave.
  Assumes the bit-parallel pins are synchronous to pclk and that software sets the
  logic sense and code type before the first strobe.
*/
// Design decisions made here: the APB slave port and the address map.
module parallel_programmer_input_port (
  input  wire logic        pclk,          // System clock
  input  wire logic        presetn,       // Asynchronous reset, active low
  input  wire logic        psel,          // APB select
  input  wire logic        penable,       // APB enable
  input  wire logic        pwrite,        // APB direction, high for write
  input  wire logic [7:0]  paddr,         // APB byte address
  input  wire logic [31:0] pwdata,        // APB write data
  output logic      [31:0] prdata,        // APB read data
  output logic             pready,        // APB ready
  output logic             pslverr,       // APB error on unmapped address
  input  wire logic [11:0] mag_data,      // Magnitude lines, index 11 is the most significant
  input  wire logic        range1,        // Channel 1 range line
  input  wire logic        pol1,          // Channel 1 polarity line
  input  wire logic        range2,        // Channel 2 range line
  input  wire logic        pol2,          // Channel 2 polarity line
  input  wire logic        chan_sel,      // High selects channel 1
  input  wire logic        strobe,        // Load strobe, acts on its falling edge
  input  wire logic        serial_in,     // Optional serial input
  output logic             busy,          // High while a transfer is in progress
  output logic             shift_clk,     // Shift clock for the serial input source
  output logic      [11:0] ch1_code,      // Channel 1 magnitude
  output logic             ch1_low_range, // Channel 1 in 0-1V range
  output logic             ch1_negative,  // Channel 1 negative output
  output logic      [11:0] ch2_code,      // Channel 2 magnitude
  output logic             ch2_low_range, // Channel 2 in 0-1V range
  output logic             ch2_negative   // Channel 2 negative output
);

  // Applies the selected logic sense to the whole group of magnitude lines.
  function automatic logic [prog_port_pkg::MAG_W-1:0] sense(input logic [prog_port_pkg::MAG_W-1:0] v,
                                                            input logic neg);
    sense = neg ? ~v : v;
  endfunction

  // Sense conversion for a single range or polarity line, so the unused upper bits cannot leak in.
  function automatic logic sense_bit(input logic v,
                                     input logic neg);
    sense_bit = v ^ neg;
  endfunction

  // True when every decade holds 0 to 9; a bad digit is flagged, never altered.
  function automatic logic bcd_valid(input logic [prog_port_pkg::MAG_W-1:0] v);
    logic ok;
    ok = 1'b1;
    for (int d = 0; d < prog_port_pkg::DIGITS; d++) begin
      if (v[d*prog_port_pkg::DIGIT_W +: prog_port_pkg::DIGIT_W] > prog_port_pkg::BCD_MAX) begin
        ok = 1'b0;
      end
    end
    bcd_valid = ok;
  endfunction

  prog_port_pkg::xfer_state_t state;

  logic                                 neg_logic;
  logic                                 bcd_mode;
  logic                                 overrun;
  logic                                 bcd_err;
  logic                                 last_ch1;
  logic                                 strobe_q;
  logic                                 strobe_fall;
  logic                                 clk_fall;
  logic                                 clk_rise;
  logic [prog_port_pkg::XFER_CNT_W-1:0] xfer_cnt;
  logic                                 xfer_done;
  logic [prog_port_pkg::MAG_W-1:0]      tmp_code;
  logic                                 tmp_low_range;
  logic                                 tmp_negative;
  logic                                 tmp_ch1;
  logic [prog_port_pkg::SERIAL_W-1:0]   serial_sr;
  logic                                 range_sel;
  logic                                 pol_sel;
  logic                                 apb_setup;
  logic                                 apb_write;
  logic                                 accept;
  logic                                 ignored;
  logic                                 ctrl_wr;
  logic                                 status_wr;

  // The divider's clock is both the internal conversion clock and the shift clock pin.
  shift_clock_divider u_div (
    .pclk      (pclk),
    .presetn   (presetn),
    .shift_clk (shift_clk),
    .clk_fall  (clk_fall),
    .clk_rise  (clk_rise)
  );

  assign strobe_fall = strobe_q & ~strobe;
  assign accept      = strobe_fall & (state == prog_port_pkg::ST_IDLE);
  // A strobe that arrives while a transfer runs would corrupt it, so it is dropped and flagged.
  assign ignored     = strobe_fall & (state != prog_port_pkg::ST_IDLE);
  assign xfer_done   = (state == prog_port_pkg::ST_XFER) && (xfer_cnt == prog_port_pkg::XFER_LAST);
  assign range_sel   = chan_sel ? range1 : range2;
  assign pol_sel     = chan_sel ? pol1 : pol2;
  assign apb_setup   = psel & ~penable;
  assign apb_write   = psel & penable & pwrite & pready;
  assign ctrl_wr     = apb_write && (paddr == prog_port_pkg::ADDR_CTRL);
  assign status_wr   = apb_write && (paddr == prog_port_pkg::ADDR_STATUS);
  // Read data is ready by the access phase, so no wait state is ever inserted.
  assign pready      = 1'b1;

  // Reset to the idle high level, so a strobe held low through reset is taken as an edge once reset ends.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_q <= 1'b1;
    end else begin
      strobe_q <= strobe;
    end
  end

  // Everything is taken on the strobe edge, so the pins are free right after it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp_code      <= prog_port_pkg::CODE_RESET;
      tmp_low_range <= 1'b0;
      tmp_negative  <= 1'b0;
      tmp_ch1       <= 1'b0;
    end else if (accept) begin
      tmp_code      <= sense(mag_data, neg_logic);
      tmp_low_range <= sense_bit(range_sel, neg_logic);
      tmp_negative  <= sense_bit(pol_sel, neg_logic);
      tmp_ch1       <= chan_sel;
    end
  end

  // The armed state waits for a falling internal clock so that busy lines up with it.
  // The transfer is counted in pclk cycles; busy drops only on the next fall after it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= prog_port_pkg::ST_IDLE;
    end else begin
      unique case (state)
        prog_port_pkg::ST_IDLE: begin
          if (accept) begin
            state <= prog_port_pkg::ST_ARMED;
          end
        end
        prog_port_pkg::ST_ARMED: begin
          if (clk_fall) begin
            state <= prog_port_pkg::ST_XFER;
          end
        end
        prog_port_pkg::ST_XFER: begin
          if (xfer_done) begin
            state <= prog_port_pkg::ST_DRAIN;
          end
        end
        prog_port_pkg::ST_DRAIN: begin
          if (clk_fall) begin
            state <= prog_port_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // The counter rests at zero outside a transfer so the next one starts clean.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xfer_cnt <= '0;
    end else if (state == prog_port_pkg::ST_XFER) begin
      xfer_cnt <= xfer_cnt + 1'b1;
    end else begin
      xfer_cnt <= '0;
    end
  end

  // Busy follows the internal clock falls, as the outside bus expects.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
    end else if (clk_fall && state == prog_port_pkg::ST_ARMED) begin
      busy <= 1'b1;
    end else if (clk_fall && state == prog_port_pkg::ST_DRAIN) begin
      busy <= 1'b0;
    end
  end

  // Each channel keeps its setting until a transfer aimed at it completes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch1_code      <= prog_port_pkg::CODE_RESET;
      ch1_low_range <= 1'b0;
      ch1_negative  <= 1'b0;
    end else if (xfer_done && tmp_ch1) begin
      ch1_code      <= tmp_code;
      ch1_low_range <= tmp_low_range;
      ch1_negative  <= tmp_negative;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch2_code      <= prog_port_pkg::CODE_RESET;
      ch2_low_range <= 1'b0;
      ch2_negative  <= 1'b0;
    end else if (xfer_done && !tmp_ch1) begin
      ch2_code      <= tmp_code;
      ch2_low_range <= tmp_low_range;
      ch2_negative  <= tmp_negative;
    end
  end

  // Software can tell which channel the latest completed transfer went to.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_ch1 <= 1'b0;
    end else if (xfer_done) begin
      last_ch1 <= tmp_ch1;
    end
  end

  // Serial data is taken when the shift clock rises, mid-way between source changes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_sr <= prog_port_pkg::SERIAL_RESET;
    end else if (clk_rise) begin
      serial_sr <= {serial_sr[prog_port_pkg::SERIAL_W-2:0], serial_in};
    end
  end

  // A change of sense or code type during a transfer only affects the next strobe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      neg_logic <= 1'b0;
      bcd_mode  <= 1'b0;
    end else if (ctrl_wr) begin
      neg_logic <= pwdata[prog_port_pkg::CTRL_NEG_LOGIC];
      bcd_mode  <= pwdata[prog_port_pkg::CTRL_BCD_MODE];
    end
  end

  // Sticky flags clear on write of one; a new event in the same cycle wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overrun <= 1'b0;
    end else if (ignored) begin
      overrun <= 1'b1;
    end else if (status_wr && pwdata[prog_port_pkg::STAT_OVERRUN]) begin
      overrun <= 1'b0;
    end
  end

  // Bad decades are still passed on; the flag only tells software the code was out of range.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcd_err <= 1'b0;
    end else if (accept && bcd_mode && !bcd_valid(sense(mag_data, neg_logic))) begin
      bcd_err <= 1'b1;
    end else if (status_wr && pwdata[prog_port_pkg::STAT_BCD_ERR]) begin
      bcd_err <= 1'b0;
    end
  end

  // Read data is prepared in the setup cycle so the access phase needs no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= prog_port_pkg::WORD_ZERO;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata  <= prog_port_pkg::WORD_ZERO;
      pslverr <= 1'b0;
      unique case (paddr)
        prog_port_pkg::ADDR_CTRL: begin
          prdata[prog_port_pkg::CTRL_NEG_LOGIC] <= neg_logic;
          prdata[prog_port_pkg::CTRL_BCD_MODE]  <= bcd_mode;
        end
        prog_port_pkg::ADDR_STATUS: begin
          prdata[prog_port_pkg::STAT_BUSY]     <= busy;
          prdata[prog_port_pkg::STAT_OVERRUN]  <= overrun;
          prdata[prog_port_pkg::STAT_BCD_ERR]  <= bcd_err;
          prdata[prog_port_pkg::STAT_LAST_CH1] <= last_ch1;
        end
        prog_port_pkg::ADDR_CH1: begin
          prdata[prog_port_pkg::MAG_W-1:0]     <= ch1_code;
          prdata[prog_port_pkg::CH_LOW_RANGE]  <= ch1_low_range;
          prdata[prog_port_pkg::CH_NEGATIVE]   <= ch1_negative;
        end
        prog_port_pkg::ADDR_CH2: begin
          prdata[prog_port_pkg::MAG_W-1:0]     <= ch2_code;
          prdata[prog_port_pkg::CH_LOW_RANGE]  <= ch2_low_range;
          prdata[prog_port_pkg::CH_NEGATIVE]   <= ch2_negative;
        end
        prog_port_pkg::ADDR_SERIAL: begin
          prdata[prog_port_pkg::SERIAL_W-1:0]  <= serial_sr;
        end
        default: begin
          pslverr <= 1'b1;
        end
      endcase
    end
  end

endmodule

// *** hdl/prog_port_pkg.sv ***
/*
  Constants, register map and types shared by the parallel programmer input port.
  Assumes a single 10 MHz pclk and an APB master with 32-bit data.
*/
// Functional notes
// - Data, range and polarity are read as positive or negative logic per static setting.
// - Magnitude is 12 lines, binary bit 12 down to 1, or three BCD decades.
// - Falling strobe edge loads temporary storage with the magnitude inputs present then.
// - Busy rises on next internal clock fall, drops on first fall after 35 us.
// - Data lines are needed only during the strobe; nothing depends on them later.
// - Range input low selects 0-10V range, high selects 0-1V range, per channel.
// - Polarity input low gives positive output, high gives negative, per channel.
// - Channel select high directs the transfer to channel 1, low to channel 2.
// - A shift clock output lets an outside source synchronise serial input data.
package prog_port_pkg;

  localparam int CLK_PERIOD_NS     = 100;
  localparam int XFER_TIME_NS      = 35000;
  localparam int STROBE_MIN_NS     = 2000;
  localparam int SHIFT_HALF_NS     = 500;
  localparam int XFER_CYCLES       = XFER_TIME_NS / CLK_PERIOD_NS;
  localparam int SHIFT_HALF_CYCLES = SHIFT_HALF_NS / CLK_PERIOD_NS;

  localparam int XFER_CNT_W  = 9;
  localparam int SHIFT_CNT_W = 3;
  localparam logic [XFER_CNT_W-1:0]  XFER_LAST  = XFER_CNT_W'(XFER_CYCLES - 1);
  localparam logic [SHIFT_CNT_W-1:0] SHIFT_LAST = SHIFT_CNT_W'(SHIFT_HALF_CYCLES - 1);

  localparam int MAG_W    = 12;
  localparam int SERIAL_W = 12;
  localparam int DIGIT_W  = 4;
  localparam int DIGITS   = 3;
  localparam logic [DIGIT_W-1:0] BCD_MAX = 4'h9;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CH1    = 8'h08;
  localparam logic [7:0] ADDR_CH2    = 8'h0C;
  localparam logic [7:0] ADDR_SERIAL = 8'h10;

  localparam int CTRL_NEG_LOGIC = 0;
  localparam int CTRL_BCD_MODE  = 1;
  localparam int STAT_BUSY      = 0;
  localparam int STAT_OVERRUN   = 1;
  localparam int STAT_BCD_ERR   = 2;
  localparam int STAT_LAST_CH1  = 3;
  localparam int CH_LOW_RANGE   = 12;
  localparam int CH_NEGATIVE    = 13;

  localparam logic [MAG_W-1:0]    CODE_RESET   = 12'h000;
  localparam logic [SERIAL_W-1:0] SERIAL_RESET = 12'h000;
  localparam logic [31:0]         WORD_ZERO    = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ARMED = 2'b01,
    ST_XFER  = 2'b11,
    ST_DRAIN = 2'b10
  } xfer_state_t;

endpackage

// *** hdl/shift_clock_divider.sv ***
/*
  Divider that makes the internal conversion clock, driven out as the shift clock.
  Assumes pclk at the package rate; edge pulses are one pclk cycle wide.
*/
module shift_clock_divider (
  input  wire logic pclk,      // System clock
  input  wire logic presetn,   // Asynchronous reset, active low
  output logic      shift_clk, // Internal clock level, also the shift clock pin
  output logic      clk_fall,  // Pulse in the cycle before shift_clk goes high to low
  output logic      clk_rise   // Pulse in the cycle before shift_clk goes low to high
);

  logic [prog_port_pkg::SHIFT_CNT_W-1:0] div_cnt;
  logic                                  half_done;

  assign half_done = (div_cnt == prog_port_pkg::SHIFT_LAST);
  assign clk_fall  = half_done & shift_clk;
  assign clk_rise  = half_done & ~shift_clk;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt <= '0;
    end else if (half_done) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  // The clock runs free so that serial data can be framed at any time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_clk <= 1'b0;
    end else if (half_done) begin
      shift_clk <= ~shift_clk;
    end
  end

endmodule

// *** sim/prog_port_monitor.sv ***
/*
  Checker for the parallel programmer input port, bound to its top module.
  Assumes one pclk domain with presetn as the asynchronous active-low reset.
*/
module prog_port_monitor (
  input wire logic        pclk,      // System clock
  input wire logic        presetn,   // Reset, active low
  input wire logic        psel,      // APB select
  input wire logic        penable,   // APB enable
  input wire logic [7:0]  paddr,     // APB address
  input wire logic [31:0] prdata,    // APB read data
  input wire logic        pslverr,   // APB error
  input wire logic        strobe,    // Load strobe
  input wire logic        busy,      // Transfer in progress
  input wire logic        shift_clk, // Shift clock
  input wire logic [11:0] ch1_code,  // Channel 1 magnitude
  input wire logic [11:0] ch2_code   // Channel 2 magnitude
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Counts busy cycles so the transfer length can be bounded without a long repetition.
  logic [9:0] busy_len;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_len <= 10'h000;
    else busy_len <= busy ? busy_len + 10'h001 : 10'h000;
  end
  a_busy_rise_edge: assert property ($rose(busy) |-> $fell(shift_clk)) else $error("busy rose off clock fall");
  a_busy_fall_edge: assert property ($fell(busy) |-> $fell(shift_clk)) else $error("busy fell off clock fall");
  a_busy_length: assert property ($fell(busy) |-> busy_len inside {[349:362]}) else $error("busy length wrong");
  a_strobe_starts: assert property ($fell(strobe) && !busy |-> ##[1:11] busy) else $error("strobe gave no busy");
  a_shift_high: assert property ($rose(shift_clk) |-> shift_clk[*5] ##1 !shift_clk) else $error("shift high phase");
  a_shift_low: assert property ($fell(shift_clk) |-> !shift_clk[*5] ##1 shift_clk) else $error("shift low phase");
  a_codes_in_busy: assert property (!$stable(ch1_code) || !$stable(ch2_code) |-> busy) else $error("code moved idle");
  a_unmapped_err: assert property (psel && !penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10})
    |=> pslverr && prdata == 32'h0) else $error("unmapped access not refused");
  cover property ($fell(busy));
  cover property ($fell(strobe) && busy);
  cover property (pslverr && penable);
endmodule

bind parallel_programmer_input_port prog_port_monitor u_mon (.pclk, .presetn, .psel, .penable, .paddr,
  .prdata, .pslverr, .strobe, .busy, .shift_clk, .ch1_code, .ch2_code);

// *** sim/strobe_controller.sv ***
/*
  Model of the outside controller that drives the bit-parallel pins.
  Assumes pclk at 100 ns; pins change just after a rising edge.
*/
module strobe_controller (
  input  wire logic        pclk,     // System clock
  input  wire logic        busy,     // Busy from the port
  output logic      [11:0] mag_data, // Magnitude lines
  output logic             range1,   // Channel 1 range line
  output logic             pol1,     // Channel 1 polarity line
  output logic             range2,   // Channel 2 range line
  output logic             pol2,     // Channel 2 polarity line
  output logic             chan_sel, // Channel select
  output logic             strobe,   // Load strobe
  output logic             stalled   // Set when a patient call gave up waiting for busy low
);
  timeunit 1ns;
  timeprecision 1ns;
  assign range2 = range1;
  assign pol2 = pol1;
  initial begin
    mag_data = 12'h000;
    range1 = 1'h0;
    pol1 = 1'h0;
    chan_sel = 1'h0;
    strobe = 1'h1;
    stalled = 1'h0;
  end
  // An impatient call strobes during busy on purpose; the wait is bounded so a stuck port cannot hang it.
  task automatic send(input logic [11:0] m, input logic r, input logic p, input logic c, input bit patient);
    int n;
    n = 0;
    while (patient && busy !== 1'h0 && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 1000) begin
      stalled <= 1'h1;
    end
    @(posedge pclk);
    mag_data <= m;
    range1 <= r;
    pol1 <= p;
    chan_sel <= c;
    strobe <= 1'h0;
    repeat (20) @(posedge pclk);
    strobe <= 1'h1;
    mag_data <= ~m;
    range1 <= ~r;
    pol1 <= ~p;
    chan_sel <= ~c;
  endtask
endmodule

// *** sim/test_parallel_programmer_input_port.sv ***
/*
  Self-checking bench for the parallel programmer input port.
  Assumes the controller model, the checker bind and the design package are compiled first.
*/
module test_parallel_programmer_input_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, perr, serial_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic [11:0] mag_data, ch1_code, ch2_code;
  logic        range1, pol1, range2, pol2, chan_sel, strobe, busy, shift_clk, stalled;
  logic        ch1_low_range, ch1_negative, ch2_low_range, ch2_negative;
  int          err_count, checks;
  initial begin
    pclk = 1'h0;
    forever #50 pclk = ~pclk;
  end
  parallel_programmer_input_port uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mag_data, .range1, .pol1, .range2, .pol2, .chan_sel, .strobe, .serial_in, .busy,
    .shift_clk, .ch1_code, .ch1_low_range, .ch1_negative, .ch2_code, .ch2_low_range, .ch2_negative);
  strobe_controller u_ctrl (.pclk, .busy, .mag_data, .range1, .pol1, .range2, .pol2, .chan_sel, .strobe,
    .stalled);
  task automatic final_report;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      err_count++;
      final_report();
    end
    q = prdata;
    perr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    while (busy !== 1'h1 && n < 15) begin
      @(posedge pclk);
      n++;
    end
    while (busy !== 1'h0 && n < 500) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 500 || n == 15) begin
      err_count++;
      final_report();
    end
  endtask
  function automatic logic [31:0] ch1_word();
    return {18'h0, ch1_negative, ch1_low_range, ch1_code};
  endfunction
  function automatic logic [31:0] ch2_word();
    return {18'h0, ch2_negative, ch2_low_range, ch2_code};
  endfunction
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    serial_in = 1'h0;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, 8'h00, 32'h0);
    check("ctrl reset", q, 32'h0);
    u_ctrl.send(12'hA5C, 1'h1, 1'h0, 1'h1, 1'h1);
    wait_done();
    check("ch1 pins", ch1_word(), 32'h0000_1A5C);
    apb(1'h0, 8'h08, 32'h0);
    check("ch1 reg", q, 32'h0000_1A5C);
    u_ctrl.send(12'h3F1, 1'h0, 1'h1, 1'h0, 1'h1);
    wait_done();
    check("ch2 pins", ch2_word(), 32'h0000_23F1);
    check("ch1 kept", ch1_word(), 32'h0000_1A5C);
    apb(1'h1, 8'h00, 32'h1);
    u_ctrl.send(12'h0F0, 1'h1, 1'h0, 1'h1, 1'h1);
    wait_done();
    check("ch1 inverted", ch1_word(), 32'h0000_2F0F);
    apb(1'h1, 8'h00, 32'h0);
    u_ctrl.send(12'h123, 1'h0, 1'h0, 1'h1, 1'h1);
    u_ctrl.send(12'h456, 1'h1, 1'h1, 1'h0, 1'h0);
    wait_done();
    check("ch1 first", ch1_word(), 32'h0000_0123);
    check("ch2 untouched", ch2_word(), 32'h0000_23F1);
    apb(1'h0, 8'h04, 32'h0);
    check("overrun set", q & 32'h2, 32'h2);
    check("status after ch1", q & 32'h9, 32'h8);
    apb(1'h1, 8'h04, 32'h2);
    apb(1'h0, 8'h04, 32'h0);
    check("overrun clear", q & 32'h2, 32'h0);
    serial_in <= 1'h1;
    apb(1'h1, 8'h00, 32'h2);
    u_ctrl.send(12'h9A1, 1'h0, 1'h0, 1'h0, 1'h1);
    wait_done();
    check("ch2 bcd", ch2_word(), 32'h0000_09A1);
    apb(1'h0, 8'h04, 32'h0);
    check("bcd flag", q & 32'h4, 32'h4);
    check("status after ch2", q & 32'h9, 32'h0);
    apb(1'h0, 8'h20, 32'h0);
    check("unmapped err", {31'h0, perr}, 32'h1);
    check("unmapped data", q, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    check("serial bits", q, 32'h0000_0FFF);
    check("controller stall", {31'h0, stalled}, 32'h0);
    final_report();
  end
endmodule
